//--- src/rph_crc16.sv
// Bytewise CRC-16 engine for the receive packet handler
`timescale 1ns/1ps
`default_nettype none
module rph_crc16 (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic        feed,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc
);
    logic [15:0] crc_q;

    // One byte through the polynomial, MSB first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ rph_pkg::CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction : crc_step

    // Feeding the checksum bytes too leaves a zero residue on a match
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crc_q <= rph_pkg::CRC_INIT;
        end else if (start) begin
            crc_q <= rph_pkg::CRC_INIT;
        end else if (feed) begin
            crc_q <= crc_step(crc_q, data);
        end
    end

    assign crc = crc_q;
endmodule : rph_crc16
`default_nettype wire

//--- src/rph_pkg.sv
// Shared constants and types of the receive packet handler
package rph_pkg;
    // Length modes
    localparam logic [1:0] LEN_FIXED = 2'h0;
    localparam logic [1:0] LEN_VAR   = 2'h1;
    localparam logic [1:0] LEN_INF   = 2'h2;
    // Address check modes
    localparam logic [1:0] ADR_NONE  = 2'h0;
    localparam logic [1:0] ADR_BC0   = 2'h2;
    localparam logic [1:0] ADR_BC01  = 2'h3;
    localparam logic [7:0] BCAST_LOW  = 8'h00;
    localparam logic [7:0] BCAST_HIGH = 8'hff;
    localparam logic [7:0] INF_MARK   = 8'hff;
    // Sync qualifier: bit 2 asks for carrier sense, low bits pick the match
    localparam int         SYNC_CS_BIT = 2;
    localparam logic [1:0] SYNC_NONE   = 2'h0;
    localparam logic [1:0] SYNC_15_16  = 2'h1;
    localparam logic [1:0] SYNC_16_16  = 2'h2;
    localparam logic [5:0] MATCH_15    = 6'h0f;
    localparam logic [5:0] MATCH_16    = 6'h10;
    localparam logic [5:0] MATCH_30    = 6'h1e;
    // CRC
    localparam logic [15:0] CRC_INIT    = 16'hffff;
    localparam logic [15:0] CRC_POLY    = 16'h8005;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;
    // Length limits
    localparam logic [7:0] FLUSH_MAX_VAR = 8'h3f;
    localparam logic [7:0] STATUS_BYTES  = 8'h02;
    localparam logic [7:0] ZERO_LEN      = 8'h00;
    localparam logic [7:0] ONE_BYTE      = 8'h01;
    // Status byte two
    localparam int         CRC_OK_BIT = 7;
    localparam logic [6:0] STAT_RSVD  = 7'h00;
    // End of receive next state
    localparam logic [1:0] RXEND_STAY_RX = 2'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef struct packed {
        logic [1:0] length_mode;
        logic [7:0] packet_length_limit;
        logic [1:0] address_check_mode;
        logic [7:0] node_address;
        logic       crc_enable;
        logic       crc_flush_enable;
        logic       status_append_enable;
        logic [7:0] sync_word_high;
        logic [7:0] sync_word_low;
        logic [2:0] sync_mode;
        logic [1:0] rx_end_next_state;
    } rph_cfg_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rph_fifo_wr_type;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_HUNT  = 4'h1,
        ST_LEN   = 4'h2,
        ST_ADDR  = 4'h3,
        ST_PAY   = 4'h4,
        ST_CRC1  = 4'h5,
        ST_CRC2  = 4'h6,
        ST_CHECK = 4'h7,
        ST_STAT1 = 4'h8,
        ST_STAT2 = 4'h9,
        ST_END   = 4'ha
    } rph_state_type;
endpackage : rph_pkg

//--- src/rph_rx_packet_handler.sv
// Receive packet handler: sync hunt, length modes, filtering, status append
// Overview of operation
// - First appended status byte is the whole 8-bit signal strength value.
// - Second status byte: top bit CRC good (or CRC off), low seven bits zero.
// - Packet order: preamble, sync, length, address, payload, two CRC bytes.
// - Preamble is alternating bits used only for bit sync before the sync word.
// - Sync word comes from two bytes; modes 3 and 7 search it doubled.
// - Fixed mode receives exactly the length register count; host keeps it nonzero.
// - Variable mode takes first byte as payload length excluding itself and CRC.
// - Variable length byte above the length register discards and restarts hunt.
// - Infinite mode receives until host stops it or changes length mode.
// - Fixed and variable packets hold 1 to 255 payload bytes.
// - Length and mode stay writable; packet ends when counter equals register.
// - Nonzero address check compares node address; 2 adds 0x00, 3 adds 0xFF.
// - Address mismatch discards and restarts hunt; matches go to the FIFO.
// - Infinite mode with address match writes 0xFF, address, then payload.
// - With CRC on, compute CRC over packet and compare with two checksum bytes.
// - CRC flush on and CRC bad: flush whole FIFO, then programmed end state.
// - With flush, packets at most 63 variable or 64 fixed, less two with status; only the variable length byte is checked.
// - Hunt for sync first; only afterwards treat bytes as aligned content.
// - Sync qualifier picks 15/16, 16/16, 30/32; codes 4 to 7 need carrier sense.
// - No FIFO writes and no filtering before a valid sync word.
`timescale 1ns/1ps
`default_nettype none
module rph_rx_packet_handler (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire rph_pkg::rph_cfg_type    cfg,
    input  wire logic                    rx_start,
    input  wire logic                    rx_stop,
    input  wire logic                    bit_valid,
    input  wire logic                    bit_data,
    input  wire logic                    carrier_sense,
    input  wire logic [7:0]              rssi,
    output rph_pkg::rph_fifo_wr_type     fifo_wr,
    output logic                         fifo_flush,
    output logic                         packet_done,
    output logic                         packet_discard,
    output logic                         sync_found,
    output logic                         crc_ok,
    output logic                         rx_active
);
    rph_pkg::rph_state_type   state_q, state_d;
    rph_pkg::rph_fifo_wr_type wr_q, wr_d;
    logic [7:0]  shift_q;
    logic [2:0]  bit_cnt_q;
    logic        byte_stb_q;
    logic [7:0]  cnt_q, cnt_d;
    logic [7:0]  len_q, len_d;
    logic        pend_q, pend_d;
    logic        flush_q, flush_d;
    logic        done_q, done_d;
    logic        discard_q, discard_d;
    logic        crc_ok_q, crc_ok_d;
    logic        sync_q;
    logic        active_q;
    logic        sync_hit;
    logic [15:0] crc_val;

    rph_sync_detect u_sync (
        .clk           (clk),
        .rstn          (rstn),
        .en            (state_q == rph_pkg::ST_HUNT),
        .bit_valid     (bit_valid),
        .bit_data      (bit_data),
        .carrier_sense (carrier_sense),
        .sync_mode     (cfg.sync_mode),
        .sync_word     ({cfg.sync_word_high, cfg.sync_word_low}),
        .found         (sync_hit)
    );

    // Bytes between sync and the last checksum byte go through the CRC
    wire in_packet = (state_q == rph_pkg::ST_LEN) || (state_q == rph_pkg::ST_ADDR) ||
                     (state_q == rph_pkg::ST_PAY) || (state_q == rph_pkg::ST_CRC1) ||
                     (state_q == rph_pkg::ST_CRC2);
    wire crc_feed  = byte_stb_q && in_packet;

    rph_crc16 u_crc (
        .clk   (clk),
        .rstn  (rstn),
        .start (sync_hit),
        .feed  (crc_feed),
        .data  (shift_q),
        .crc   (crc_val)
    );

    // Byte assembly restarts at the sync hit so bytes line up with it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift_q    <= 8'h00;
            bit_cnt_q  <= 3'h0;
            byte_stb_q <= 1'b0;
        end else begin
            byte_stb_q <= in_packet && bit_valid && (bit_cnt_q == rph_pkg::BIT_LAST);
            if (sync_hit || !in_packet) begin
                bit_cnt_q <= 3'h0;
            end else if (bit_valid) begin
                shift_q   <= {shift_q[6:0], bit_data};
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
        end
    end

    // Filter decisions on the byte just assembled
    wire [7:0] cnt_next  = cnt_q + rph_pkg::ONE_BYTE;
    wire       flush_big = cfg.crc_flush_enable &&
                           (shift_q > (rph_pkg::FLUSH_MAX_VAR -
                            (cfg.status_append_enable ? rph_pkg::STATUS_BYTES : rph_pkg::ZERO_LEN)));
    wire       len_bad   = (shift_q > cfg.packet_length_limit) ||
                           (shift_q == rph_pkg::ZERO_LEN) || flush_big;
    wire       adr_ok    = (shift_q == cfg.node_address) ||
                           ((cfg.address_check_mode == rph_pkg::ADR_BC0 ||
                             cfg.address_check_mode == rph_pkg::ADR_BC01) &&
                            shift_q == rph_pkg::BCAST_LOW) ||
                           (cfg.address_check_mode == rph_pkg::ADR_BC01 &&
                            shift_q == rph_pkg::BCAST_HIGH);
    wire       adr_on    = cfg.address_check_mode != rph_pkg::ADR_NONE;
    // Live length and mode so the host may retune them mid-packet
    wire       pay_end   = (cfg.length_mode == rph_pkg::LEN_FIXED && cnt_next == cfg.packet_length_limit) ||
                           (cfg.length_mode == rph_pkg::LEN_VAR && cnt_next == len_q);
    wire rph_pkg::rph_state_type after_pay = cfg.crc_enable ? rph_pkg::ST_CRC1 :
                           (cfg.status_append_enable ? rph_pkg::ST_STAT1 : rph_pkg::ST_END);
    wire rph_pkg::rph_state_type after_hdr = pay_end ? after_pay : rph_pkg::ST_PAY;
    wire       crc_good  = crc_val == rph_pkg::CRC_RESIDUE;

    // Packet sequencing
    always_comb begin
        state_d   = state_q;
        wr_d      = '0;
        cnt_d     = cnt_q;
        len_d     = len_q;
        pend_d    = 1'b0;
        flush_d   = 1'b0;
        done_d    = 1'b0;
        discard_d = 1'b0;
        crc_ok_d  = crc_ok_q;
        case (state_q)
            rph_pkg::ST_IDLE: begin
                if (rx_start) begin
                    state_d = rph_pkg::ST_HUNT;
                end
            end
            rph_pkg::ST_HUNT: begin
                cnt_d = rph_pkg::ZERO_LEN;
                if (sync_hit) begin
                    state_d = (cfg.length_mode == rph_pkg::LEN_VAR) ? rph_pkg::ST_LEN :
                              (adr_on ? rph_pkg::ST_ADDR : rph_pkg::ST_PAY);
                end
            end
            rph_pkg::ST_LEN: begin
                if (byte_stb_q) begin
                    if (len_bad) begin
                        discard_d = 1'b1;
                        state_d   = rph_pkg::ST_HUNT;
                    end else begin
                        len_d      = shift_q;
                        wr_d.valid = 1'b1;
                        wr_d.data  = shift_q;
                        state_d    = adr_on ? rph_pkg::ST_ADDR : rph_pkg::ST_PAY;
                    end
                end
            end
            rph_pkg::ST_ADDR: begin
                if (byte_stb_q) begin
                    if (!adr_ok) begin
                        discard_d = 1'b1;
                        state_d   = rph_pkg::ST_HUNT;
                    end else begin
                        cnt_d      = cnt_next;
                        wr_d.valid = 1'b1;
                        state_d    = after_hdr;
                        if (cfg.length_mode == rph_pkg::LEN_INF) begin
                            wr_d.data = rph_pkg::INF_MARK;
                            pend_d    = 1'b1;
                        end else begin
                            wr_d.data = shift_q;
                        end
                    end
                end
            end
            rph_pkg::ST_PAY: begin
                if (byte_stb_q) begin
                    cnt_d      = cnt_next;
                    wr_d.valid = 1'b1;
                    wr_d.data  = shift_q;
                    if (pay_end) begin
                        state_d = after_pay;
                    end
                end
            end
            rph_pkg::ST_CRC1: begin
                if (byte_stb_q) begin
                    state_d = rph_pkg::ST_CRC2;
                end
            end
            rph_pkg::ST_CRC2: begin
                if (byte_stb_q) begin
                    state_d = rph_pkg::ST_CHECK;
                end
            end
            rph_pkg::ST_CHECK: begin
                crc_ok_d = crc_good;
                if (cfg.crc_flush_enable && !crc_good) begin
                    flush_d = 1'b1;
                    state_d = rph_pkg::ST_END;
                end else begin
                    state_d = cfg.status_append_enable ? rph_pkg::ST_STAT1 : rph_pkg::ST_END;
                end
            end
            rph_pkg::ST_STAT1: begin
                if (!cfg.crc_enable) begin
                    crc_ok_d = 1'b1;
                end
                wr_d.valid = 1'b1;
                wr_d.data  = rssi;
                state_d    = rph_pkg::ST_STAT2;
            end
            rph_pkg::ST_STAT2: begin
                wr_d.valid = 1'b1;
                wr_d.data  = {crc_ok_q, rph_pkg::STAT_RSVD};
                state_d    = rph_pkg::ST_END;
            end
            rph_pkg::ST_END: begin
                done_d  = 1'b1;
                state_d = (cfg.rx_end_next_state == rph_pkg::RXEND_STAY_RX) ?
                          rph_pkg::ST_HUNT : rph_pkg::ST_IDLE;
            end
            default: begin
                state_d = rph_pkg::ST_IDLE;
            end
        endcase
        // Address byte that follows the infinite-mode marker
        if (pend_q) begin
            wr_d.valid = 1'b1;
            wr_d.data  = shift_q;
        end
        if (rx_stop) begin
            state_d = rph_pkg::ST_IDLE;
        end
    end

    // State and registered outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= rph_pkg::ST_IDLE;
            wr_q      <= '0;
            cnt_q     <= 8'h00;
            len_q     <= 8'h00;
            pend_q    <= 1'b0;
            flush_q   <= 1'b0;
            done_q    <= 1'b0;
            discard_q <= 1'b0;
            crc_ok_q  <= 1'b0;
            sync_q    <= 1'b0;
            active_q  <= 1'b0;
        end else begin
            state_q   <= state_d;
            wr_q      <= wr_d;
            cnt_q     <= cnt_d;
            len_q     <= len_d;
            pend_q    <= pend_d;
            flush_q   <= flush_d;
            done_q    <= done_d;
            discard_q <= discard_d;
            crc_ok_q  <= crc_ok_d;
            sync_q    <= sync_hit;
            active_q  <= state_d != rph_pkg::ST_IDLE;
        end
    end

    assign fifo_wr        = wr_q;
    assign fifo_flush     = flush_q;
    assign packet_done    = done_q;
    assign packet_discard = discard_q;
    assign sync_found     = sync_q;
    assign crc_ok         = crc_ok_q;
    assign rx_active      = active_q;

    sequence s_inf_addr;
        state_q == rph_pkg::ST_ADDR && byte_stb_q && adr_ok && !rx_stop &&
        cfg.length_mode == rph_pkg::LEN_INF;
    endsequence
    sequence s_mark_then_addr;
        ##1 (wr_q.valid && wr_q.data == rph_pkg::INF_MARK)
        ##1 (wr_q.valid && wr_q.data == $past(shift_q, 2));
    endsequence

    property p_stat1;
        @(posedge clk) disable iff (!rstn)
        state_q == rph_pkg::ST_STAT1 |=> wr_q.valid && wr_q.data == $past(rssi);
    endproperty
    a_stat1: assert property (p_stat1) else $error("status byte one not rssi");
    property p_stat2;
        @(posedge clk) disable iff (!rstn)
        state_q == rph_pkg::ST_STAT2 |=> wr_q.valid && wr_q.data[6:0] == rph_pkg::STAT_RSVD &&
            wr_q.data[rph_pkg::CRC_OK_BIT] == crc_ok_q;
    endproperty
    a_stat2: assert property (p_stat2) else $error("status byte two wrong");
    property p_len_over;
        @(posedge clk) disable iff (!rstn)
        state_q == rph_pkg::ST_LEN && byte_stb_q && shift_q > cfg.packet_length_limit && !rx_stop
        |=> packet_discard && !wr_q.valid && state_q == rph_pkg::ST_HUNT;
    endproperty
    a_len_over: assert property (p_len_over) else $error("oversize packet not discarded");
    property p_len_write;
        @(posedge clk) disable iff (!rstn)
        state_q == rph_pkg::ST_LEN && byte_stb_q && !len_bad |=> wr_q.valid && wr_q.data == $past(shift_q);
    endproperty
    a_len_write: assert property (p_len_write) else $error("length byte not written");
    property p_addr_miss;
        @(posedge clk) disable iff (!rstn)
        state_q == rph_pkg::ST_ADDR && byte_stb_q && !adr_ok |=> packet_discard && !wr_q.valid;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("address mismatch not discarded");
    property p_inf_mark;
        @(posedge clk) disable iff (!rstn) s_inf_addr |-> s_mark_then_addr;
    endproperty
    a_inf_mark: assert property (p_inf_mark) else $error("marker and address order wrong");
    property p_flush;
        @(posedge clk) disable iff (!rstn)
        state_q == rph_pkg::ST_CHECK && cfg.crc_flush_enable && !crc_good && !rx_stop
        |=> fifo_flush ##1 packet_done;
    endproperty
    a_flush: assert property (p_flush) else $error("bad crc did not flush");
    property p_quiet_hunt;
        @(posedge clk) disable iff (!rstn)
        state_q == rph_pkg::ST_HUNT && $past(state_q) == rph_pkg::ST_HUNT && !pend_q |-> !wr_q.valid;
    endproperty
    a_quiet_hunt: assert property (p_quiet_hunt) else $error("fifo write before sync");
    property p_fixed_end;
        @(posedge clk) disable iff (!rstn)
        state_q == rph_pkg::ST_PAY && byte_stb_q && cfg.length_mode == rph_pkg::LEN_FIXED &&
        cnt_next == cfg.packet_length_limit |=> state_q != rph_pkg::ST_PAY;
    endproperty
    a_fixed_end: assert property (p_fixed_end) else $error("fixed packet overran length");
endmodule : rph_rx_packet_handler
`default_nettype wire

//--- src/rph_sync_detect.sv
// Sync word correlator for the receive packet handler
`timescale 1ns/1ps
`default_nettype none
module rph_sync_detect (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       en,
    input  wire logic       bit_valid,
    input  wire logic       bit_data,
    input  wire logic       carrier_sense,
    input  wire logic [2:0] sync_mode,
    input  wire logic [15:0] sync_word,
    output logic            found
);
    logic [31:0] sr_q;
    logic        found_q;

    // Count of ones in a word
    function automatic logic [5:0] ones32(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++) begin
            n = n + {5'h00, v[i]};
        end
        return n;
    endfunction : ones32

    // Agreement with the word, single and doubled
    wire  [5:0] agree16 = ones32({16'h0000, ~(sr_q[15:0] ^ sync_word)});
    wire  [5:0] agree32 = ones32(~(sr_q ^ {sync_word, sync_word}));
    wire  [1:0] sub     = sync_mode[1:0];
    wire        cs_ok   = ~sync_mode[rph_pkg::SYNC_CS_BIT] | carrier_sense;
    wire        hit     = (sub == rph_pkg::SYNC_NONE)  ? 1'b1 :
                          (sub == rph_pkg::SYNC_15_16) ? (agree16 >= rph_pkg::MATCH_15) :
                          (sub == rph_pkg::SYNC_16_16) ? (agree16 == rph_pkg::MATCH_16) :
                          (agree32 >= rph_pkg::MATCH_30);

    // Preamble bits merely pass through the correlator; cleared whenever en is low (not hunting)
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sr_q    <= 32'h0000_0000;
            found_q <= 1'b0;
        end else begin
            found_q <= en & ~found_q & hit & cs_ok;
            if (!en) begin
                sr_q <= 32'h0000_0000;
            end else if (bit_valid) begin
                sr_q <= {sr_q[30:0], bit_data};
            end
        end
    end

    assign found = found_q;

    property p_found_needs_en;
        @(posedge clk) disable iff (!rstn) found_q |-> $past(en);
    endproperty
    a_found_needs_en: assert property (p_found_needs_en) else $error("sync found while not hunting");
endmodule : rph_sync_detect
`default_nettype wire

//--- tb/rph_host_model.sv
// Host side model: collects receive FIFO bytes
`timescale 1ns/1ps
`default_nettype none
module rph_host_model (
    input wire logic                     clk,
    input wire rph_pkg::rph_fifo_wr_type fifo_wr,
    input wire logic                     fifo_flush
);
    logic [7:0] rxq[$];
    // Each run empties the queue before its frame, so a flush only drops the current packet
    always @(posedge clk) begin
        if (fifo_flush) rxq.delete();
        else if (fifo_wr.valid) rxq.push_back(fifo_wr.data);
    end
endmodule : rph_host_model
`default_nettype wire

//--- tb/tb_rx_packet_handler.sv
// Testbench of the receive packet handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_rx_packet_handler;
    logic clk = 0, rstn = 0, rx_start = 0, rx_stop = 0, bit_valid = 0, bit_data = 0, cs = 0;
    logic [7:0] rssi = 8'h00;
    rph_pkg::rph_cfg_type cfg = '0, base, k, k2;
    rph_pkg::rph_fifo_wr_type fifo_wr;
    logic fifo_flush, packet_done, packet_discard, sync_found, crc_ok, rx_active;
    int fail_count = 0, n_tests = 0, seed = 32'h217f7f3d;
    logic disc, flushed, done, synced;
    logic [7:0] pl[$], ex[$];

    rph_rx_packet_handler DUT (.clk(clk), .rstn(rstn), .cfg(cfg), .rx_start(rx_start), .rx_stop(rx_stop),
        .bit_valid(bit_valid), .bit_data(bit_data), .carrier_sense(cs), .rssi(rssi), .fifo_wr(fifo_wr),
        .fifo_flush(fifo_flush), .packet_done(packet_done), .packet_discard(packet_discard),
        .sync_found(sync_found), .crc_ok(crc_ok), .rx_active(rx_active));
    rph_host_model host (.clk(clk), .fifo_wr(fifo_wr), .fifo_flush(fifo_flush));

    // 125 MHz clock
    initial forever #4 clk = ~clk;
    // Sticky event flags, cleared per packet
    always @(posedge clk) begin
        if (packet_discard) disc <= 1'b1;
        if (fifo_flush) flushed <= 1'b1;
        if (packet_done) done <= 1'b1;
        if (sync_found) synced <= 1'b1;
    end

    // MSB first, four cycles per bit to respect spacing
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk) bit_valid <= 1'b1;
            bit_data <= b[i];
            @(posedge clk) bit_valid <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : send_byte

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction : crc_step

    // One frame: preamble, sync, content, optional CRC (bad flips a bit); k2 takes over sw bytes before the end
    task automatic run(input rph_pkg::rph_cfg_type kc, input logic [7:0] b[$], input bit bad,
                       input int sw = 0, input rph_pkg::rph_cfg_type k2 = '0);
        logic [15:0] c = 16'hffff;
        @(posedge clk) rx_stop <= 1'b1;
        {disc, flushed, done, synced} = 4'h0;
        host.rxq.delete();
        // Settings change only once the stop has parked the block in idle
        @(posedge clk) rx_stop <= 1'b0;
        cfg <= kc;
        rssi <= 8'($random(seed));
        rx_start <= 1'b1;
        @(posedge clk) rx_start <= 1'b0;
        foreach (b[i]) c = crc_step(c, b[i]);
        if (kc.sync_mode[1:0] == 2'h3) b = {kc.sync_word_high, kc.sync_word_low, b};
        b = {8'haa, 8'haa, kc.sync_word_high, kc.sync_word_low, b};
        if (kc.crc_enable) b = {b, c[15:8], c[7:0] ^ {7'h00, bad}};
        foreach (b[i]) begin
            if (sw != 0 && i == b.size() - sw) cfg <= k2;
            send_byte(b[i]);
        end
        repeat (12) @(posedge clk);
    endtask : run

    task automatic chk_q();
        `CHK("count", ex.size(), host.rxq.size())
        foreach (ex[i]) if (i < host.rxq.size()) `CHK("byte", ex[i], host.rxq[i])
    endtask : chk_q

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // Watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        finish_test();
    end

    initial begin
        base = '0;
        base.sync_word_high = 8'hd3;
        base.sync_word_low = 8'h91;
        base.sync_mode = 3'h2;
        base.packet_length_limit = 8'h08;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        // Fixed length with status bytes, shortest length first
        for (int t = 0; t < 4; t++) begin
            k = base;
            k.status_append_enable = 1'b1;
            if (t == 3) k.sync_mode = 3'h1;
            k.packet_length_limit = t ? 8'(($random(seed) & 15) + 1) : 8'h01;
            pl = {};
            for (int i = 0; i < k.packet_length_limit; i++) pl.push_back(8'($random(seed)));
            run(k, pl, 0);
            ex = {pl, rssi, 8'h80};
            chk_q();
            `CHK("done", 1'b1, done)
            `CHK("active", 1'b0, rx_active)
            $display("test fixed %0d done", t);
        end
        // Variable length, broadcast 0xff address, good CRC
        k = base;
        k.length_mode = rph_pkg::LEN_VAR;
        k.address_check_mode = rph_pkg::ADR_BC01;
        k.node_address = 8'h5a;
        k.crc_enable = 1'b1;
        k.status_append_enable = 1'b1;
        pl = {8'h03, 8'hff, 8'h11, 8'h22};
        run(k, pl, 0);
        ex = {pl, rssi, 8'h80};
        chk_q();
        `CHK("crc_ok", 1'b1, crc_ok)
        $display("test variable done");
        // Length byte above limit is dropped
        k = base;
        k.length_mode = rph_pkg::LEN_VAR;
        run(k, {8'h09, 8'h01}, 0);
        `CHK("discard", 1'b1, disc)
        ex = {};
        chk_q();
        // Address mismatch is dropped
        k = base;
        k.address_check_mode = rph_pkg::ADR_BC0;
        k.node_address = 8'h5a;
        run(k, {8'h33, 8'h44}, 0);
        `CHK("discard", 1'b1, disc)
        ex = {};
        chk_q();
        // Bad CRC with flush
        k = base;
        k.packet_length_limit = 8'h02;
        k.crc_enable = 1'b1;
        k.crc_flush_enable = 1'b1;
        run(k, {8'h01, 8'h02}, 1);
        `CHK("flush", 1'b1, flushed)
        `CHK("crc_ok", 1'b0, crc_ok)
        ex = {};
        chk_q();
        $display("test filters done");
        // Infinite length with matching address
        k = base;
        k.length_mode = rph_pkg::LEN_INF;
        k.address_check_mode = 2'h1;
        k.node_address = 8'h5a;
        run(k, {8'h5a, 8'h07, 8'h08}, 0);
        ex = {8'hff, 8'h5a, 8'h07, 8'h08};
        chk_q();
        `CHK("active", 1'b1, rx_active)
        $display("test infinite done");
        // Doubled sync qualified by carrier sense, then a frame with last byte 0x00 without carrier
        for (int t = 1; t >= 0; t--) begin
            k = base;
            k.sync_mode = 3'h7;
            k.packet_length_limit = 8'h02;
            k.status_append_enable = 1'b1;
            cs <= t[0];
            pl = {8'h3c, 8'(t)};
            run(k, pl, 0);
            if (t) ex = {pl, rssi, 8'h80};
            else ex = {};
            chk_q();
            `CHK("sync", t[0], synced)
            $display("test carrier %0d done", t);
        end
        // Long packet: infinite first, fixed once few bytes remain, then stay receiving
        k = base;
        k.length_mode = rph_pkg::LEN_INF;
        k.packet_length_limit = 8'h06;
        k.status_append_enable = 1'b1;
        k.rx_end_next_state = rph_pkg::RXEND_STAY_RX;
        k2 = k;
        k2.length_mode = rph_pkg::LEN_FIXED;
        pl = {};
        repeat (6) pl.push_back(8'($random(seed)));
        run(k, pl, 0, 3, k2);
        ex = {pl, rssi, 8'h80};
        chk_q();
        `CHK("done", 1'b1, done)
        `CHK("active", 1'b1, rx_active)
        $display("test mode switch done");
        finish_test();
    end
endmodule : tb_rx_packet_handler
`default_nettype wire
